// *** pkg/iprb_pkg.sv ***
/*
  Constants and types for the interrupt priority register bank: word
  addresses, slot layout, per-line field indices and reset values.
  Assumes a 32-bit byte-addressed register port.
*/
package iprb_pkg;

  typedef logic [1:0] iprb_prio_t;
  typedef logic [2:0] iprb_word_t;

  localparam int NUM_WORDS   = 6;
  localparam int SLOTS       = 4;
  localparam int NUM_LINES   = 24;
  localparam int SLOT_LSB    = 6;
  localparam int SLOT_STRIDE = 8;

  localparam logic [31:0] ADDR_WORD2 = 32'hE000E408;
  localparam logic [31:0] ADDR_WORD3 = 32'hE000E40C;
  localparam logic [31:0] ADDR_WORD4 = 32'hE000E410;
  localparam logic [31:0] ADDR_WORD5 = 32'hE000E414;
  localparam logic [31:0] ADDR_WORD6 = 32'hE000E418;
  localparam logic [31:0] ADDR_WORD7 = 32'hE000E41C;

  // slot positions in the data word
  localparam logic [31:0] DATA_MASK  = 32'hC0C0C0C0;
  localparam logic [23:0] LINE_IMPL  = 24'hFF8FFD;
  localparam logic [4:0]  FIRST_LINE = 5'h08;

  localparam iprb_prio_t PRIO_RESET = 2'h0;
  localparam iprb_prio_t PRIO_MOST  = 2'h0;
  localparam iprb_prio_t PRIO_LEAST = 2'h3;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // storage index of each field (line number minus FIRST_LINE)
  localparam int IDX_TWOWIRE0   = 0;
  localparam int IDX_MULTIRATE  = 2;
  localparam int IDX_CMP_TOUCH  = 3;
  localparam int IDX_WATCHDOG   = 4;
  localparam int IDX_BROWNOUT   = 5;
  localparam int IDX_FLASH      = 6;
  localparam int IDX_WAKE       = 7;
  localparam int IDX_CONV_SEQA  = 8;
  localparam int IDX_CONV_SEQB  = 9;
  localparam int IDX_CONV_THR   = 10;
  localparam int IDX_CONV_OVR   = 11;
  localparam int IDX_CNT_TIMER  = 15;
  localparam int IDX_PIN0       = 16;

endpackage

// *** design/iprb_arbiter.sv ***
/*
  Priority arbiter: picks the most urgent requesting line, lowest line
  number on a tie. Assumes requests are already pending and enabled.
*/
`timescale 1ns/1ns
module iprb_arbiter (
  input  wire logic                               clk,
  input  wire logic                               sys_rst,
  input  wire logic [iprb_pkg::NUM_LINES-1:0]     irq_req,
  input  wire logic [2*iprb_pkg::NUM_LINES-1:0]   prio_flat,
  output logic                                    arb_valid,
  output logic [4:0]                              arb_line,
  output iprb_pkg::iprb_prio_t                    arb_level
);
  import iprb_pkg::*;

  logic       next_valid;
  logic [4:0] next_line;
  iprb_prio_t next_level;
  logic       better_seen;

  // strict compare keeps the lower line on equal levels
  always_comb begin
    next_valid = 1'b0;
    next_line  = 5'h00;
    next_level = PRIO_LEAST;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (irq_req[i] && LINE_IMPL[i]) begin
        if (!next_valid || prio_flat[2*i +: 2] < next_level) begin
          next_valid = 1'b1;
          next_line  = FIRST_LINE + 5'(i);
          next_level = prio_flat[2*i +: 2];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      arb_valid <= 1'b0;
      arb_line  <= 5'h00;
      arb_level <= PRIO_RESET;
    end else begin
      arb_valid <= next_valid;
      arb_line  <= next_line;
      arb_level <= next_level;
    end
  end

  // independent check: nobody beats the chosen line
  always_comb begin
    better_seen = 1'b0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (irq_req[i] && LINE_IMPL[i] && next_valid) begin
        if (prio_flat[2*i +: 2] < next_level) better_seen = 1'b1;
        if (prio_flat[2*i +: 2] == next_level &&
            FIRST_LINE + 5'(i) < next_line) better_seen = 1'b1;
      end
    end
  end

  property p_arb_best;
    @(posedge clk) disable iff (sys_rst)
    !better_seen;
  endproperty
  a_arb_best: assert property (p_arb_best)
    else $error("arbiter winner is not the most urgent lowest line");

  property p_arb_valid;
    @(posedge clk) disable iff (sys_rst)
    ##1 arb_valid == $past(|(irq_req & LINE_IMPL));
  endproperty
  a_arb_valid: assert property (p_arb_valid)
    else $error("arbiter valid does not follow implemented requests");

endmodule

// *** design/iprb_bank.sv ***
/*
  Interrupt priority register bank: six priority words, register port,
  per-line priority outputs and the arbiter feeding the core.
  Assumes one-cycle strobes, never both at once, and read data taken in
  the cycle after the read strobe.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - each field is two bits, 0 most urgent and 3 least urgent.
// - the six bits below each slot drop writes and read as zero.
// - each word has four slots at 7:6, 15:14, 23:22 and 31:30.
// - word 2 holds two-wire port 0, multi-rate timer, comparator/touch.
// - word 3 holds watchdog, brown-out, flash and wake-up timer.
// - word 4 holds the four converter priorities.
// - word 5 holds only the counter/timer priority at 31:30.
// - word 6 holds pin interrupts 0 to 3 in slot order.
// - word 7 holds pin interrupts 4 to 7 in slot order.
module iprb_bank (
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  input  wire logic [31:0]                    bus_addr,
  input  wire logic [31:0]                    bus_wdata,
  input  wire logic                           bus_wr,
  input  wire logic                           bus_rd,
  output logic [31:0]                         bus_rdata,
  input  wire logic [iprb_pkg::NUM_LINES-1:0] irq_req,
  output logic                                arb_valid,
  output logic [4:0]                          arb_line,
  output iprb_pkg::iprb_prio_t                arb_level,
  output iprb_pkg::iprb_prio_t                prio_twowire_port0,
  output iprb_pkg::iprb_prio_t                prio_multirate_timer,
  output iprb_pkg::iprb_prio_t                prio_comparator_touch,
  output iprb_pkg::iprb_prio_t                prio_watchdog,
  output iprb_pkg::iprb_prio_t                prio_brownout,
  output iprb_pkg::iprb_prio_t                prio_flash_ctrl,
  output iprb_pkg::iprb_prio_t                prio_wake_timer,
  output iprb_pkg::iprb_prio_t                prio_conv_sequence_a,
  output iprb_pkg::iprb_prio_t                prio_conv_sequence_b,
  output iprb_pkg::iprb_prio_t                prio_conv_threshold,
  output iprb_pkg::iprb_prio_t                prio_conv_overrun,
  output iprb_pkg::iprb_prio_t                prio_counter_timer,
  output iprb_pkg::iprb_prio_t                prio_pin_irq_0,
  output iprb_pkg::iprb_prio_t                prio_pin_irq_1,
  output iprb_pkg::iprb_prio_t                prio_pin_irq_2,
  output iprb_pkg::iprb_prio_t                prio_pin_irq_3,
  output iprb_pkg::iprb_prio_t                prio_pin_irq_4,
  output iprb_pkg::iprb_prio_t                prio_pin_irq_5,
  output iprb_pkg::iprb_prio_t                prio_pin_irq_6,
  output iprb_pkg::iprb_prio_t                prio_pin_irq_7
);
  import iprb_pkg::*;

  iprb_prio_t             prio      [0:NUM_LINES-1];
  iprb_prio_t             next_prio [0:NUM_LINES-1];
  logic [31:0]            next_rdata;
  logic [31:0]            rd_word;
  logic                   hit;
  iprb_word_t             word_idx;
  logic [2*NUM_LINES-1:0] prio_flat;

  // address decode, full byte address compare
  always_comb begin
    hit      = 1'b1;
    word_idx = 3'h0;
    if (bus_addr == ADDR_WORD2) begin
      word_idx = 3'h0;
    end else if (bus_addr == ADDR_WORD3) begin
      word_idx = 3'h1;
    end else if (bus_addr == ADDR_WORD4) begin
      word_idx = 3'h2;
    end else if (bus_addr == ADDR_WORD5) begin
      word_idx = 3'h3;
    end else if (bus_addr == ADDR_WORD6) begin
      word_idx = 3'h4;
    end else if (bus_addr == ADDR_WORD7) begin
      word_idx = 3'h5;
    end else begin
      hit = 1'b0;
    end
  end

  // gather the addressed word; reserved slots stay zero
  always_comb begin
    int base;
    base    = int'(word_idx) * SLOTS;
    rd_word = '0;
    for (int k = 0; k < SLOTS; k++) begin
      if (LINE_IMPL[base + k]) begin
        rd_word[SLOT_LSB + SLOT_STRIDE*k +: 2] = prio[base + k];
      end
    end
  end

  // only slot bits are written; the low six of each byte are dropped
  always_comb begin
    int base;
    base = int'(word_idx) * SLOTS;
    for (int i = 0; i < NUM_LINES; i++) begin
      next_prio[i] = prio[i];
    end
    if (bus_wr && hit) begin
      for (int k = 0; k < SLOTS; k++) begin
        if (LINE_IMPL[base + k]) begin
          next_prio[base + k] = bus_wdata[SLOT_LSB + SLOT_STRIDE*k +: 2];
        end
      end
    end
  end

  // read data stands one cycle only, zero otherwise and when unmapped
  always_comb begin
    next_rdata = RDATA_RESET;
    if (bus_rd && hit) begin
      next_rdata = rd_word & DATA_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        prio[i] <= PRIO_RESET;
      end
      bus_rdata <= RDATA_RESET;
    end else begin
      for (int i = 0; i < NUM_LINES; i++) begin
        prio[i] <= next_prio[i];
      end
      bus_rdata <= next_rdata;
    end
  end

  // flatten for the arbiter, one entry per line
  generate
    for (genvar g = 0; g < NUM_LINES; g++) begin : g_flat
      assign prio_flat[2*g +: 2] = prio[g];
    end
  endgenerate

  assign prio_twowire_port0    = prio[IDX_TWOWIRE0];
  assign prio_multirate_timer  = prio[IDX_MULTIRATE];
  assign prio_comparator_touch = prio[IDX_CMP_TOUCH];
  assign prio_watchdog         = prio[IDX_WATCHDOG];
  assign prio_brownout         = prio[IDX_BROWNOUT];
  assign prio_flash_ctrl       = prio[IDX_FLASH];
  assign prio_wake_timer       = prio[IDX_WAKE];
  assign prio_conv_sequence_a  = prio[IDX_CONV_SEQA];
  assign prio_conv_sequence_b  = prio[IDX_CONV_SEQB];
  assign prio_conv_threshold   = prio[IDX_CONV_THR];
  assign prio_conv_overrun     = prio[IDX_CONV_OVR];
  assign prio_counter_timer    = prio[IDX_CNT_TIMER];
  assign prio_pin_irq_0        = prio[IDX_PIN0];
  assign prio_pin_irq_1        = prio[IDX_PIN0 + 1];
  assign prio_pin_irq_2        = prio[IDX_PIN0 + 2];
  assign prio_pin_irq_3        = prio[IDX_PIN0 + 3];
  assign prio_pin_irq_4        = prio[IDX_PIN0 + 4];
  assign prio_pin_irq_5        = prio[IDX_PIN0 + 5];
  assign prio_pin_irq_6        = prio[IDX_PIN0 + 6];
  assign prio_pin_irq_7        = prio[IDX_PIN0 + 7];

  // arbiter sees a field in the same cycle it lands in the bank
  iprb_arbiter u_arbiter (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .irq_req   (irq_req),
    .prio_flat (prio_flat),
    .arb_valid (arb_valid),
    .arb_line  (arb_line),
    .arb_level (arb_level)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_rd_reserved_zero;
    bus_rd |=> (bus_rdata & ~DATA_MASK) == 32'h00000000;
  endproperty
  a_rd_reserved_zero: assert property (p_rd_reserved_zero)
    else $error("reserved data bits read non-zero");

  property p_rd_idle_zero;
    !bus_rd |=> bus_rdata == 32'h00000000;
  endproperty
  a_rd_idle_zero: assert property (p_rd_idle_zero)
    else $error("read data present without a read strobe");

  property p_wr_rd_back;
    bus_wr && bus_addr == ADDR_WORD6 ##1 bus_rd && bus_addr == ADDR_WORD6
      |=> bus_rdata == ($past(bus_wdata, 2) & DATA_MASK);
  endproperty
  a_wr_rd_back: assert property (p_wr_rd_back)
    else $error("word 6 read back differs from last write");

  property p_word2_reserved;
    bus_rd && bus_addr == ADDR_WORD2 |=> bus_rdata[15:14] == 2'h0;
  endproperty
  a_word2_reserved: assert property (p_word2_reserved)
    else $error("word 2 reserved slot reads non-zero");

  property p_word2_write;
    bus_wr && bus_addr == ADDR_WORD2 |=>
      prio_comparator_touch == $past(bus_wdata[31:30]) &&
      prio_twowire_port0 == $past(bus_wdata[7:6]);
  endproperty
  a_word2_write: assert property (p_word2_write)
    else $error("word 2 write not seen on fields next cycle");

  property p_word3_write;
    bus_wr && bus_addr == ADDR_WORD3 |=>
      prio_brownout == $past(bus_wdata[15:14]) &&
      prio_flash_ctrl == $past(bus_wdata[23:22]);
  endproperty
  a_word3_write: assert property (p_word3_write)
    else $error("word 3 write not seen on fields next cycle");

  property p_word4_write;
    bus_wr && bus_addr == ADDR_WORD4 |=>
      prio_conv_overrun == $past(bus_wdata[31:30]) &&
      prio_conv_sequence_b == $past(bus_wdata[15:14]);
  endproperty
  a_word4_write: assert property (p_word4_write)
    else $error("word 4 write not seen on fields next cycle");

  property p_word5_only_top;
    bus_rd && bus_addr == ADDR_WORD5 |=> bus_rdata[29:0] == 30'h00000000;
  endproperty
  a_word5_only_top: assert property (p_word5_only_top)
    else $error("word 5 reserved slots read non-zero");

  property p_word6_write;
    bus_wr && bus_addr == ADDR_WORD6 |=>
      prio_pin_irq_0 == $past(bus_wdata[7:6]) &&
      prio_pin_irq_3 == $past(bus_wdata[31:30]);
  endproperty
  a_word6_write: assert property (p_word6_write)
    else $error("word 6 write not seen on pin fields");

  property p_word7_write;
    bus_wr && bus_addr == ADDR_WORD7 |=>
      prio_pin_irq_4 == $past(bus_wdata[7:6]) &&
      prio_pin_irq_6 == $past(bus_wdata[23:22]);
  endproperty
  a_word7_write: assert property (p_word7_write)
    else $error("word 7 write not seen on pin fields");

  property p_unmapped_write;
    bus_wr && !hit |=> $stable(prio_flat);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("write to an unmapped address changed a field");

  property p_reset_clear;
    disable iff (1'b0)
    sys_rst |=> prio_flat == '0 && bus_rdata == 32'h00000000;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("fields not zero after reset");

  // winner must have requested and carry its own field's level
  property p_level_range;
    arb_valid |-> arb_line >= FIRST_LINE &&
      (($past(irq_req) >> (arb_line - FIRST_LINE)) & 24'h000001) != '0 &&
      arb_level == iprb_prio_t'($past(prio_flat) >>
                                (2 * (arb_line - FIRST_LINE)));
  endproperty
  a_level_range: assert property (p_level_range)
    else $error("winner not requesting or level not its field");

endmodule

// *** sim/iprb_core_model.sv ***
/*
  Core-side bus master model for the priority register bank.
  Assumes one-cycle strobes and read data in the cycle after the strobe.
*/
`timescale 1ns/1ns
module iprb_core_model (
  input  wire logic        clk,
  output logic [31:0]      bus_addr,
  output logic [31:0]      bus_wdata,
  output logic             bus_wr,
  output logic             bus_rd,
  input  wire logic [31:0] bus_rdata
);
  initial begin
    bus_addr  = 32'h00000000;
    bus_wdata = 32'h00000000;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    #1;
    d = bus_rdata;
  endtask

  // write then read the same word with no gap between the strobes
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr    <= 1'b0;
    bus_rd    <= 1'b1;
    bus_wdata <= ~d;
    @(posedge clk);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    #1;
    q = bus_rdata;
  endtask
endmodule

// *** sim/testbench.sv ***
/*
  Self-checking bench for the priority register bank.
  Assumes the core model above drives the register port.
*/
`timescale 1ns/1ns
module testbench;
  import iprb_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [23:0] irq_req = 24'h000000;
  logic [31:0] bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] bus_rdata;
  logic        arb_valid;
  logic [4:0]  arb_line;
  logic [1:0]  arb_level;
  wire  [39:0] prio_all;
  logic [31:0] rd_back;
  int          error_cnt = 0;
  int          samples_checked = 0;
  // slot 0..3 carry 0,1,2,3 plus junk in the unimplemented bits
  localparam logic [31:0] PAT = 32'hFFBF7F3F;
  logic [31:0] addrs [6] = '{ADDR_WORD2, ADDR_WORD3, ADDR_WORD4,
                             ADDR_WORD5, ADDR_WORD6, ADDR_WORD7};
  logic [31:0] masks [6] = '{32'hC0C000C0, 32'hC0C0C0C0, 32'hC0C0C0C0,
                             32'hC0000000, 32'hC0C0C0C0, 32'hC0C0C0C0};

  always #2 clk = ~clk;

  iprb_core_model iprb_core_model_inst (
    .clk       (clk),
    .bus_addr  (bus_addr),
    .bus_wdata (bus_wdata),
    .bus_wr    (bus_wr),
    .bus_rd    (bus_rd),
    .bus_rdata (bus_rdata)
  );

  iprb_bank iprb_bank_inst (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .bus_addr              (bus_addr),
    .bus_wdata             (bus_wdata),
    .bus_wr                (bus_wr),
    .bus_rd                (bus_rd),
    .bus_rdata             (bus_rdata),
    .irq_req               (irq_req),
    .arb_valid             (arb_valid),
    .arb_line              (arb_line),
    .arb_level             (arb_level),
    .prio_twowire_port0    (prio_all[39:38]),
    .prio_multirate_timer  (prio_all[37:36]),
    .prio_comparator_touch (prio_all[35:34]),
    .prio_watchdog         (prio_all[33:32]),
    .prio_brownout         (prio_all[31:30]),
    .prio_flash_ctrl       (prio_all[29:28]),
    .prio_wake_timer       (prio_all[27:26]),
    .prio_conv_sequence_a  (prio_all[25:24]),
    .prio_conv_sequence_b  (prio_all[23:22]),
    .prio_conv_threshold   (prio_all[21:20]),
    .prio_conv_overrun     (prio_all[19:18]),
    .prio_counter_timer    (prio_all[17:16]),
    .prio_pin_irq_0        (prio_all[15:14]),
    .prio_pin_irq_1        (prio_all[13:12]),
    .prio_pin_irq_2        (prio_all[11:10]),
    .prio_pin_irq_3        (prio_all[9:8]),
    .prio_pin_irq_4        (prio_all[7:6]),
    .prio_pin_irq_5        (prio_all[5:4]),
    .prio_pin_irq_6        (prio_all[3:2]),
    .prio_pin_irq_7        (prio_all[1:0])
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    iprb_core_model_inst.rd(a, d);
    chk({32'h00000000, d}, {32'h00000000, exp});
  endtask

  // arbiter output is registered; look two clock edges after the request is driven
  task automatic arb_chk(input logic [23:0] req, input logic [7:0] exp);
    @(posedge clk);
    irq_req <= req;
    repeat (2) @(posedge clk);
    #1;
    chk({56'h0, arb_valid, arb_line, arb_level}, {56'h0, exp});
  endtask

  initial begin
    #20000;
    error_cnt++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd_chk(addrs[i], 32'h00000000);
    chk({24'h0, prio_all}, 64'h0);
    $display("test reset done");

    for (int i = 0; i < 6; i++) iprb_core_model_inst.wr(addrs[i], PAT);
    #1;
    chk({24'h0, prio_all}, 64'h2C6C6F1B1B);
    for (int i = 0; i < 6; i++) rd_chk(addrs[i], PAT & masks[i]);
    $display("test field map done");

    // unmapped neighbours must not alias onto the bank
    iprb_core_model_inst.wr(32'hE000E404, 32'h00000000);
    iprb_core_model_inst.wr(32'hE000E420, 32'h00000000);
    rd_chk(32'hE000E404, 32'h00000000);
    rd_chk(32'hE000E420, 32'h00000000);
    rd_chk(ADDR_WORD2, PAT & masks[0]);
    rd_chk(ADDR_WORD7, PAT & masks[5]);
    $display("test unmapped done");

    for (int i = 0; i < 6; i++) iprb_core_model_inst.wr(addrs[i], 32'hFFFFFFFF);
    #1;
    chk({24'h0, prio_all}, 64'hFFFFFFFFFF);
    for (int i = 0; i < 6; i++) rd_chk(addrs[i], masks[i]);
    $display("test all ones done");

    iprb_core_model_inst.wr_rd(ADDR_WORD6, PAT, rd_back);
    chk({32'h00000000, rd_back}, {32'h00000000, PAT & masks[4]});
    $display("test back to back done");

    iprb_core_model_inst.wr(ADDR_WORD6, 32'h00000000);
    arb_chk(24'h060010, {1'b1, 5'h19, 2'h0});
    arb_chk(24'h800010, {1'b1, 5'h0C, 2'h3});
    arb_chk(24'h000002, {1'b0, 5'h00, 2'h3});
    $display("test arbiter done");

    // reset in mid-run must clear fields written earlier
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({24'h0, prio_all}, 64'h0);
    rd_chk(ADDR_WORD7, 32'h00000000);
    $display("test mid reset done");
    close_out();
  end
endmodule
